/* hw/frep_cfg.svh */
// constants for the flash row erase / program sequencer
`ifndef FREP_CFG_SVH
`define FREP_CFG_SVH
// ***************************************************
// control register field positions
// ***************************************************
`define FREP_BIT_PGM_SEL   7
`define FREP_BIT_CFG_SEL   6
`define FREP_BIT_ERASE     4
`define FREP_BIT_ABORT     3
`define FREP_BIT_PERMIT    2
`define FREP_BIT_TRIGGER   1
// ***************************************************
// unlock keys and holding register blank value
// ***************************************************
`define FREP_KEY1          8'h55
`define FREP_KEY2          8'hAA
`define FREP_BLANK         8'hFF
// ***************************************************
// geometry
// ***************************************************
`define FREP_PTR_W         22
`define FREP_HOLD_N        32
`define FREP_ROW_BYTES     64
// ***************************************************
// timing: long cycle, in microseconds, at 40 MHz
// ***************************************************
`define FREP_CLK_MHZ       40
`define FREP_LONG_US       2000
`define FREP_LONG_CYC      (`FREP_LONG_US * `FREP_CLK_MHZ)
// ***************************************************
// controller register offsets (apb, byte addresses)
// ***************************************************
`define FREP_A_CTRL        12'h000
`define FREP_A_PTR         12'h004
`define FREP_A_DATA        12'h008
`define FREP_A_STAT        12'h00C
`define FREP_A_LAST        12'h010
// controller ctrl register bits
`define FREP_CMD_GO        0
`define FREP_CMD_ERASE     1
`define FREP_CMD_SKIPKEY   2
`define FREP_CMD_NOPERMIT  3
`endif

/* hw/frep_pkg.sv */
// types shared by both ends of the flash sequencer link
package frep_pkg;
   // operation kinds on the core side of the link
   typedef enum logic [1:0] {
      FREP_OP_NONE,
      FREP_OP_CTRL_WR,
      FREP_OP_KEY_WR,
      FREP_OP_TBL_WR
   } frep_op_t;
endpackage

/* hw/frep_if.sv */
// link between the processor-core end and the flash sequencer end
`timescale 1ns/100ps
`include "frep_cfg.svh"
interface frep_if;
   import frep_pkg::*;
   // one access per cycle from core, stall back from device
   frep_op_t                  op;
   logic [7:0]                wdata;
   logic [`FREP_PTR_W-1:0]    table_pointer;
   logic                      stall;
   logic [7:0]                flash_control_reg;
   modport core (output op, output wdata, output table_pointer,
                 input stall, input flash_control_reg);
   modport dev  (input op, input wdata, input table_pointer,
                 output stall, output flash_control_reg);
endinterface

/* hw/frep_timer.sv */
// internal programming timer: counts one long cycle
`timescale 1ns/100ps
`include "frep_cfg.svh"
module frep_timer #(
   parameter int unsigned CYCLES = `FREP_LONG_CYC
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control
   input  wire logic start,
   output logic      done
);
   logic [31:0] cnt_r;

   // load on start, count down, pulse done at one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 32'h0000_0000;
      end else if (start) begin
         cnt_r <= CYCLES;
      end else if (cnt_r != 32'h0000_0000) begin
         cnt_r <= cnt_r - 32'h0000_0001;
      end
   end

   assign done = (cnt_r == 32'h0000_0001);
endmodule // frep_timer

/* hw/frep_dev.sv */
// flash sequencer: holding registers, unlock, row erase and block program
`timescale 1ns/100ps
`include "frep_cfg.svh"
module frep_dev #(
   parameter int unsigned LONG_CYC = `FREP_LONG_CYC,
   parameter int unsigned MEM_BYTES = 4096,
   parameter int unsigned AW = 12
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // link to core
   frep_if.dev              lnk,
   // array read port for verification
   input  wire logic [AW-1:0] mem_raddr,
   output logic [7:0]         mem_rdata,
   // status
   output logic             busy
);
   import frep_pkg::*;

   typedef enum logic [1:0] {FD_IDLE, FD_KEY1, FD_KEY2} frep_key_t;
   typedef enum logic [1:0] {FD_RUN_IDLE, FD_RUN_LONG, FD_RUN_COMMIT}
      frep_run_t;

   frep_key_t         key_r;
   frep_run_t         run_r;
   logic [7:0]        hold_r [`FREP_HOLD_N];
   logic [7:0]        mem_r [MEM_BYTES];
   logic [7:0]        ctl_r;
   logic              erase_op_r;
   logic [AW-1:0]     base_r;
   logic              tmr_start;
   logic              tmr_done;
   logic              go;
   logic              ctl_wr;
   logic              fresh_r;
   logic              inflight_r;
   logic              bad_trig;
   logic              cut_seen;

   // ***************************************************
   // unlock sequence tracking
   // ***************************************************
   assign ctl_wr = (lnk.op == FREP_OP_CTRL_WR);
   // any other access between keys and trigger breaks the sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_r <= FD_IDLE;
      end else if (lnk.op == FREP_OP_KEY_WR) begin
         if (lnk.wdata == `FREP_KEY1)
            key_r <= FD_KEY1;
         else if (lnk.wdata == `FREP_KEY2 && key_r == FD_KEY1)
            key_r <= FD_KEY2;
         else
            key_r <= FD_IDLE;
      end else if (lnk.op != FREP_OP_NONE) begin
         key_r <= FD_IDLE;
      end
   end

   // trigger honoured only when permit set and keys just before
   assign go = ctl_wr && lnk.wdata[`FREP_BIT_TRIGGER]
               && lnk.wdata[`FREP_BIT_PERMIT]
               && key_r == FD_KEY2 && run_r == FD_RUN_IDLE;

   // ***************************************************
   // control register
   // ***************************************************
   // ***************************************************
   // reset-cut detection
   // ***************************************************
   // deliberately outside the reset: it must survive one to report it;
   // unknown until the first reset is released, which clears it
   // limitation: a power loss in real silicon would need a nonvolatile bit
   always_ff @(posedge pclk) begin
      if (go)
         inflight_r <= 1'b1;
      else if (run_r == FD_RUN_COMMIT || (fresh_r && presetn))
         inflight_r <= 1'b0;
   end

   // abort causes: a refused trigger, or a reset that cut a cycle short
   assign bad_trig = ctl_wr && run_r == FD_RUN_IDLE
                     && lnk.wdata[`FREP_BIT_TRIGGER] && !go;
   assign cut_seen = fresh_r && inflight_r;

   // the first cycle after reset looks back at the cut detector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r   <= 8'h00;
         fresh_r <= 1'b1;
      end else begin
         fresh_r <= 1'b0;
         if (ctl_wr && run_r == FD_RUN_IDLE) begin
            ctl_r[`FREP_BIT_PGM_SEL] <= lnk.wdata[`FREP_BIT_PGM_SEL];
            ctl_r[`FREP_BIT_CFG_SEL] <= lnk.wdata[`FREP_BIT_CFG_SEL];
            ctl_r[`FREP_BIT_ERASE]   <= lnk.wdata[`FREP_BIT_ERASE];
            ctl_r[`FREP_BIT_PERMIT]  <= lnk.wdata[`FREP_BIT_PERMIT];
            // software may clear the flag; a set below still wins
            ctl_r[`FREP_BIT_ABORT]   <= lnk.wdata[`FREP_BIT_ABORT];
            if (go)
               ctl_r[`FREP_BIT_TRIGGER] <= 1'b1;
         end
         if (bad_trig || cut_seen)
            ctl_r[`FREP_BIT_ABORT] <= 1'b1;
         if (tmr_done) begin
            ctl_r[`FREP_BIT_TRIGGER] <= 1'b0;
            if (erase_op_r)
               ctl_r[`FREP_BIT_ERASE] <= 1'b0;
         end
      end
   end
   assign lnk.flash_control_reg = ctl_r;

   // ***************************************************
   // long cycle sequencing
   // ***************************************************
   // the operation kind and target are frozen at trigger time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r      <= FD_RUN_IDLE;
         erase_op_r <= 1'b0;
         base_r     <= '0;
      end else begin
         unique case (run_r)
            FD_RUN_IDLE: if (go) begin
               run_r      <= FD_RUN_LONG;
               erase_op_r <= lnk.wdata[`FREP_BIT_ERASE]
                             & lnk.wdata[`FREP_BIT_PGM_SEL];
               base_r     <= lnk.table_pointer[AW-1:0];
            end
            FD_RUN_LONG: if (tmr_done)
               run_r <= FD_RUN_COMMIT;
            FD_RUN_COMMIT:
               run_r <= FD_RUN_IDLE;
            default:
               run_r <= FD_RUN_IDLE;
         endcase
      end
   end
   assign tmr_start = go;

   frep_timer #(.CYCLES(LONG_CYC)) u_tmr (
      .pclk   (pclk),
      .presetn(presetn),
      .start  (tmr_start),
      .done   (tmr_done)
   );

   // core held from trigger until the array is updated
   assign lnk.stall = (run_r != FD_RUN_IDLE);
   assign busy      = lnk.stall;

   // ***************************************************
   // holding registers
   // ***************************************************
   // short writes only: the array is untouched here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `FREP_HOLD_N; i++)
            hold_r[i] <= `FREP_BLANK;
      end else if (run_r == FD_RUN_COMMIT && !erase_op_r) begin
         for (int i = 0; i < `FREP_HOLD_N; i++)
            hold_r[i] <= `FREP_BLANK;
      end else if (lnk.op == FREP_OP_TBL_WR && run_r == FD_RUN_IDLE) begin
         hold_r[lnk.table_pointer[4:0]] <= lnk.wdata;
      end
   end

   // ***************************************************
   // flash array
   // ***************************************************
   // array has no reset: it models nonvolatile contents
   always_ff @(posedge pclk) begin
      if (run_r == FD_RUN_COMMIT) begin
         for (int i = 0; i < `FREP_ROW_BYTES; i++) begin
            if (erase_op_r) begin
               // whole aligned row, low six pointer bits ignored
               mem_r[{base_r[AW-1:6], 6'(i)}] <= 8'hFF;
            end else if (i < `FREP_HOLD_N) begin
               // and-merge: FFh bytes keep the cell unchanged
               mem_r[{base_r[AW-1:5], 5'(i)}] <=
                  mem_r[{base_r[AW-1:5], 5'(i)}] & hold_r[i];
            end
         end
      end
   end
   assign mem_rdata = mem_r[mem_raddr];
endmodule // frep_dev

/* hw/frep_core.sv */
// core-side end: apb-driven issuer of table writes, unlock and trigger
`timescale 1ns/100ps
`include "frep_cfg.svh"
module frep_core (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // link to device
   frep_if.core             lnk
);
   import frep_pkg::*;

   typedef enum logic [2:0] {FC_IDLE, FC_CTL, FC_K1, FC_K2, FC_TRIG,
                             FC_WAIT} frep_cst_t;

   frep_cst_t                st_r;
   logic [`FREP_PTR_W-1:0]   ptr_r;
   logic [3:0]               cmd_r;
   logic [7:0]               last_r;
   logic                     wr_acc;
   logic                     ok_addr;

   assign ok_addr = paddr < `FREP_A_LAST && paddr[1:0] == 2'b00;
   assign wr_acc  = psel && penable && pwrite && ok_addr;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !ok_addr;

   // ***************************************************
   // command and pointer registers
   // ***************************************************
   // data write is a pre-incrementing table write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_r <= '0;
         cmd_r <= 4'h0;
      end else begin
         if (st_r == FC_IDLE && wr_acc && paddr == `FREP_A_PTR)
            ptr_r <= pwdata[`FREP_PTR_W-1:0];
         else if (st_r == FC_IDLE && wr_acc && paddr == `FREP_A_DATA)
            ptr_r <= ptr_r + 22'(1);
         if (st_r == FC_IDLE && wr_acc && paddr == `FREP_A_CTRL)
            cmd_r <= pwdata[3:0];
         else if (st_r == FC_WAIT && !lnk.stall)
            cmd_r[`FREP_CMD_GO] <= 1'b0;
      end
   end

   // ***************************************************
   // sequence: control, key 55h, key AAh, trigger, wait
   // ***************************************************
   // keys issued back to back so nothing slips between them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= FC_IDLE;
      end else begin
         unique case (st_r)
            FC_IDLE: if (wr_acc && paddr == `FREP_A_CTRL
                         && pwdata[`FREP_CMD_GO])
               st_r <= FC_CTL;
            FC_CTL:  st_r <= cmd_r[`FREP_CMD_SKIPKEY] ? FC_TRIG : FC_K1;
            FC_K1:   st_r <= FC_K2;
            FC_K2:   st_r <= FC_TRIG;
            FC_TRIG: st_r <= FC_WAIT;
            FC_WAIT: if (!lnk.stall)
               st_r <= FC_IDLE;
            default: st_r <= FC_IDLE;
         endcase
      end
   end

   // drive the link from the current step
   always_comb begin
      lnk.op            = FREP_OP_NONE;
      lnk.wdata         = 8'h00;
      lnk.table_pointer = ptr_r;
      unique case (st_r)
         FC_CTL: begin
            lnk.op    = FREP_OP_CTRL_WR;
            lnk.wdata = 8'h00;
            lnk.wdata[`FREP_BIT_PGM_SEL] = 1'b1;
            lnk.wdata[`FREP_BIT_PERMIT]  = ~cmd_r[`FREP_CMD_NOPERMIT];
            lnk.wdata[`FREP_BIT_ERASE]   = cmd_r[`FREP_CMD_ERASE];
         end
         FC_K1: begin
            lnk.op    = FREP_OP_KEY_WR;
            lnk.wdata = `FREP_KEY1;
         end
         FC_K2: begin
            lnk.op    = FREP_OP_KEY_WR;
            lnk.wdata = `FREP_KEY2;
         end
         FC_TRIG: begin
            lnk.op    = FREP_OP_CTRL_WR;
            lnk.wdata = 8'h00;
            lnk.wdata[`FREP_BIT_PGM_SEL] = 1'b1;
            lnk.wdata[`FREP_BIT_PERMIT]  = ~cmd_r[`FREP_CMD_NOPERMIT];
            lnk.wdata[`FREP_BIT_ERASE]   = cmd_r[`FREP_CMD_ERASE];
            lnk.wdata[`FREP_BIT_TRIGGER] = 1'b1;
         end
         default: begin
            if (st_r == FC_IDLE && wr_acc && paddr == `FREP_A_DATA) begin
               lnk.op            = FREP_OP_TBL_WR;
               lnk.wdata         = pwdata[7:0];
               lnk.table_pointer = ptr_r + 22'(1);
            end
         end
      endcase
   end

   // last control value seen, for status reads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         last_r <= 8'h00;
      else
         last_r <= lnk.flash_control_reg;
   end

   // read mux
   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         `FREP_A_CTRL: prdata = {28'h000_0000, cmd_r};
         `FREP_A_PTR:  prdata = {10'h000, ptr_r};
         `FREP_A_STAT: prdata = {23'h00_0000, st_r != FC_IDLE, last_r};
         default:      prdata = 32'h0000_0000;
      endcase
   end
endmodule // frep_core

/* testbench/frep_chk.sv */
// link checker for the flash sequencer pair
`timescale 1ns/100ps
`include "frep_cfg.svh"
module frep_chk #(
   parameter int unsigned LONG_CYC = `FREP_LONG_CYC
) (
   // clock and reset
   input wire logic                   pclk,
   input wire logic                   presetn,
   // link
   input frep_pkg::frep_op_t          op,
   input wire logic [7:0]             wdata,
   input wire logic [`FREP_PTR_W-1:0] table_pointer,
   input wire logic                   stall,
   input wire logic [7:0]             flash_control_reg
);
   import frep_pkg::*;
   int unsigned run_r;
   // stall length, counted here since repetition cannot hold LONG_CYC
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) run_r <= 0;
      else if (stall) run_r <= run_r + 1;
      else run_r <= 0;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ***************************************************
   // unlock pair and trigger write
   // ***************************************************
   sequence keys_s;
      op == FREP_OP_KEY_WR && wdata == `FREP_KEY1
      ##1 op == FREP_OP_KEY_WR && wdata == `FREP_KEY2;
   endsequence
   sequence trig_s;
      op == FREP_OP_CTRL_WR && wdata[`FREP_BIT_TRIGGER] && !stall;
   endsequence
   stall_len_a: assert property (
      $fell(stall) |-> run_r == LONG_CYC + 1)
      else $error("long cycle length wrong");
   stall_max_a: assert property (run_r <= LONG_CYC + 1)
      else $error("stall runs too long");
   trig_keyed_a: assert property (
      keys_s ##1 (trig_s ##0 wdata[`FREP_BIT_PERMIT]) |=> stall)
      else $error("unlocked trigger did not start");
   stall_cause_a: assert property ($rose(stall) |->
      $past(op) == FREP_OP_CTRL_WR && $past(op, 2) == FREP_OP_KEY_WR &&
      $past(wdata, 2) == `FREP_KEY2 && $past(wdata, 3) == `FREP_KEY1)
      else $error("stall without unlock pair");
   no_permit_a: assert property (
      trig_s ##0 !wdata[`FREP_BIT_PERMIT] |=> !stall)
      else $error("started without permit");
   abort_set_a: assert property (
      (trig_s ##0 (wdata[`FREP_BIT_PERMIT] &&
      !($past(wdata) == `FREP_KEY2 && $past(op) == FREP_OP_KEY_WR))) |=>
      ##[0:1] (flash_control_reg[`FREP_BIT_ABORT] && !stall))
      else $error("bad trigger not flagged");
   trig_clear_a: assert property ($fell(stall) |-> ##[0:1]
      !flash_control_reg[`FREP_BIT_TRIGGER] &&
      !flash_control_reg[`FREP_BIT_ERASE])
      else $error("trigger or erase bit not cleared");
   trig_hold_a: assert property (
      $rose(stall) |-> flash_control_reg[`FREP_BIT_TRIGGER])
      else $error("trigger bit low while running");
endmodule // frep_chk

/* testbench/tb_flash_row_erase_program.sv */
// self-checking bench for the flash sequencer pair
`timescale 1ns/100ps
`include "frep_cfg.svh"
module tb_flash_row_erase_program;
   import frep_pkg::*;
   localparam int unsigned LC = 20;
   logic        pclk, presetn, psel, penable, pwrite;
   logic        pready, pslverr, busy, err;
   logic [11:0] paddr, mem_raddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  mem_rdata;
   int          num_errors, checks, cyc;
   frep_if i_frep_if ();
   frep_dev #(.LONG_CYC(LC)) i_frep_dev (.pclk(pclk), .presetn(presetn),
      .lnk(i_frep_if.dev), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata),
      .busy(busy));
   frep_core i_frep_core (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lnk(i_frep_if.core));
   frep_chk #(.LONG_CYC(LC)) i_frep_chk (.pclk(pclk), .presetn(presetn),
      .op(i_frep_if.op), .wdata(i_frep_if.wdata),
      .table_pointer(i_frep_if.table_pointer), .stall(i_frep_if.stall),
      .flash_control_reg(i_frep_if.flash_control_reg));
   // clock, 25 ns
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // ***************************************************
   // common tasks
   // ***************************************************
   task end_of_test;
      if (num_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // one apb transfer; held until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // polls status until the core is idle; the hang guard ends a stuck wait
   task wait_done;
      do apb(1'b0, `FREP_A_STAT, 32'h0000_0000);
      while (q[8] !== 1'b0);
   endtask
   task rmem(input logic [11:0] a, input logic [7:0] e);
      @(posedge pclk);
      mem_raddr <= a;
      @(negedge pclk);
      chk(32'(mem_rdata), 32'(e), "array byte");
   endtask
   task erase(input logic [11:0] p);
      apb(1'b1, `FREP_A_PTR, 32'(p));
      apb(1'b1, `FREP_A_CTRL, 32'h0000_0003);
      wait_done();
   endtask
   // ***************************************************
   // scenarios
   // ***************************************************
   task t_reset;
      apb(1'b0, `FREP_A_STAT, 32'h0000_0000);
      chk(q, 32'h0000_0000, "reset status");
      apb(1'b0, `FREP_A_LAST, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001, "unmapped slverr");
   endtask
   // pointer low bits all set: must still hit the aligned row
   task t_erase;
      erase(12'h0BF);
      for (int i = 0; i < 64; i++) rmem(12'h080 + 12'(i), 8'hFF);
      chk(32'({q[7], q[4], q[1]}), 32'h0000_0004, "erase status");
   endtask
   task t_prog;
      apb(1'b1, `FREP_A_PTR, 32'h0000_007F);
      for (int i = 0; i < 32; i++)
         apb(1'b1, `FREP_A_DATA, (i == 5) ? 32'h0000_00FF : 32'(8'h0F ^ i));
      apb(1'b1, `FREP_A_CTRL, 32'h0000_0001);
      wait_done();
      apb(1'b0, `FREP_A_PTR, 32'h0000_0000);
      chk(q, 32'h0000_009F, "pointer after loads");
      for (int i = 0; i < 32; i++)
         rmem(12'h080 + 12'(i), (i == 5) ? 8'hFF : 8'(8'h0F ^ i));
      rmem(12'h0A0, 8'hFF);
      // second pass loads one byte only; rest must be blank again
      apb(1'b1, `FREP_A_PTR, 32'h0000_007F);
      apb(1'b1, `FREP_A_DATA, 32'h0000_00F0);
      apb(1'b1, `FREP_A_CTRL, 32'h0000_0001);
      wait_done();
      rmem(12'h080, 8'h00);
      rmem(12'h081, 8'h0E);
   endtask
   task t_row3;
      erase(12'h0C5);
      for (int i = 0; i < 64; i++) rmem(12'h0C0 + 12'(i), 8'hFF);
      rmem(12'h082, 8'h0D);
   endtask
   task t_refuse;
      apb(1'b1, `FREP_A_PTR, 32'h0000_00A0);
      apb(1'b1, `FREP_A_DATA, 32'h0000_0000);
      apb(1'b1, `FREP_A_CTRL, 32'h0000_0005);
      wait_done();
      chk(32'({q[7], q[3]}), 32'h0000_0003, "abort status");
      rmem(12'h0A1, 8'hFF);
      apb(1'b1, `FREP_A_CTRL, 32'h0000_0009);
      wait_done();
      chk(32'({q[7], q[3]}), 32'h0000_0003, "abort no permit");
      rmem(12'h0A1, 8'hFF);
   endtask
   // reset cut mid-cycle: flag raised, holding bytes blank, array intact
   task t_cut;
      apb(1'b1, `FREP_A_PTR, 32'h0000_00DF);
      apb(1'b1, `FREP_A_CTRL, 32'h0000_0001);
      while (busy !== 1'b1) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `FREP_A_STAT, 32'h0000_0000);
      chk(32'({q[8], q[3]}), 32'h0000_0001, "abort after cut");
      chk(32'(busy), 32'h0000_0000, "busy after cut");
      rmem(12'h0C1, 8'hFF);
      // refill the erased row in two halves; leftover byte must be gone
      apb(1'b1, `FREP_A_PTR, 32'h0000_00BF);
      apb(1'b1, `FREP_A_DATA, 32'h0000_003C);
      apb(1'b1, `FREP_A_CTRL, 32'h0000_0001);
      wait_done();
      rmem(12'h0C1, 8'hFF);
      apb(1'b1, `FREP_A_PTR, 32'h0000_00DF);
      apb(1'b1, `FREP_A_DATA, 32'h0000_005A);
      apb(1'b1, `FREP_A_CTRL, 32'h0000_0001);
      wait_done();
      rmem(12'h0C0, 8'h3C);
      rmem(12'h0E0, 8'h5A);
   endtask
   // ***************************************************
   // main sequence and hang guard
   // ***************************************************
   initial begin
      {presetn, psel, penable, pwrite} = 4'b0000;
      paddr = 12'h000;
      mem_raddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_erase();
      t_prog();
      t_row3();
      t_refuse();
      t_cut();
      end_of_test();
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
endmodule // tb_flash_row_erase_program
